// *** hw/eblas_pkg.sv ***
// constants and types for the external bus lane and strobe block
// Overview of operation
// - select pin picks space id or address
// - strobe only in first cycle of access
// - strobe starts transfer, any ready ends it
// - granted: strobe input runs select and waits
// - 32-bit byte write: one lane enable low
// - 32-bit halfword writes: upper or lower pair
// - 32-bit reads assert all four lane enables
// - 16-bit byte writes follow fixed lane codes
// - 16-bit halfword and word write lane codes
// - 16-bit reads: two accesses, fixed codes
// - after ready, second access of a pair starts at once
// - request releases bus after transfer, grant
package eblas_pkg;

  localparam int ADDR_W      = 32;
  localparam int SPACE_W     = 4;
  localparam int LOW_ADDR_W  = 28;
  localparam int LANES       = 4;
  localparam int WAIT_W      = 4;

  localparam logic [LANES-1:0] LANES_ALL   = 4'h0;
  localparam logic [LANES-1:0] LANES_IDLE  = 4'hF;
  localparam logic [LANES-1:0] L32_HALF0   = 4'hC;
  localparam logic [LANES-1:0] L32_HALF1   = 4'h3;
  localparam logic [LANES-1:0] L16_BYTE0   = 4'h1;
  localparam logic [LANES-1:0] L16_BYTE1   = 4'h2;
  localparam logic [LANES-1:0] L16_BYTE2   = 4'h5;
  localparam logic [LANES-1:0] L16_BYTE3   = 4'h6;
  localparam logic [LANES-1:0] L16_HALF1   = 4'h4;
  localparam logic [LANES-1:0] L16_SECOND  = 4'h4;
  localparam logic [LANES-1:0] ONE_LANE    = 4'h1;
  localparam logic [WAIT_W-1:0] FOREIGN_WAITS = 4'h2;

  typedef enum logic [1:0] {
    EBLAS_BYTE,
    EBLAS_HALF,
    EBLAS_WORD
  } eblas_size_t;

  typedef struct packed {
    logic [ADDR_W-1:0]  addr;
    logic [SPACE_W-1:0] space;
    logic               write;
    eblas_size_t        size;
    logic               bus16;
    logic               use_int_wait;
    logic [WAIT_W-1:0]  waits;
  } eblas_req_t;

endpackage

// *** hw/eblas_top.sv ***
// external bus master port: strobe, lane enables, ready, grant
`timescale 1ns/1ps
module eblas_top #(
  parameter logic [3:0] P_FOREIGN_WAITS = eblas_pkg::FOREIGN_WAITS
) (
  input  wire logic                                i_clk_sys,
  input  wire logic                                i_nrst,
  input  wire logic                                i_req_valid,
  input  wire eblas_pkg::eblas_req_t               i_req,
  output logic                                     o_req_ready,
  output logic                                     o_done,
  input  wire logic                                i_space_pin_select,
  input  wire logic                                i_transfer_strobe_n,
  output logic                                     o_transfer_strobe_n,
  output logic                                     o_transfer_strobe_oe,
  output logic [eblas_pkg::LANES-1:0]              o_lane_enable_n,
  output logic                                     o_lane_enable_oe,
  output logic [eblas_pkg::LOW_ADDR_W-1:0]         o_addr,
  output logic [eblas_pkg::SPACE_W-1:0]            o_space_identifier,
  output logic                                     o_space_identifier_oe,
  input  wire logic [eblas_pkg::SPACE_W-1:0]       i_space_identifier,
  input  wire logic                                i_ready_n,
  output logic                                     o_combined_ready_out_n,
  input  wire logic                                i_bus_request_n,
  output logic                                     o_bus_grant_n,
  output logic                                     o_foreign_start,
  output logic [eblas_pkg::SPACE_W-1:0]            o_foreign_space
);

  ////////////////////////////////////////////////////////////////////////
  // lane enable decode

  function automatic logic [eblas_pkg::LANES-1:0] lane_code(
    input logic                   bus16,
    input logic                   write,
    input eblas_pkg::eblas_size_t size,
    input logic [1:0]             lo,
    input logic                   second
  );
    logic [eblas_pkg::LANES-1:0] code;
    code = eblas_pkg::LANES_ALL;
    if (!write) begin
      if (bus16 && second) begin
        code = eblas_pkg::L16_SECOND;
      end else begin
        code = eblas_pkg::LANES_ALL;
      end
    end else if (!bus16) begin
      unique case (size)
        eblas_pkg::EBLAS_BYTE: begin
          code = ~(eblas_pkg::ONE_LANE << lo);
        end
        eblas_pkg::EBLAS_HALF: begin
          code = lo[1] ? eblas_pkg::L32_HALF1
                       : eblas_pkg::L32_HALF0;
        end
        default: begin
          code = eblas_pkg::LANES_ALL;
        end
      endcase
    end else begin
      unique case (size)
        eblas_pkg::EBLAS_BYTE: begin
          unique case (lo)
            2'h0:    code = eblas_pkg::L16_BYTE0;
            2'h1:    code = eblas_pkg::L16_BYTE1;
            2'h2:    code = eblas_pkg::L16_BYTE2;
            default: code = eblas_pkg::L16_BYTE3;
          endcase
        end
        eblas_pkg::EBLAS_HALF: begin
          code = lo[1] ? eblas_pkg::L16_HALF1
                       : eblas_pkg::LANES_ALL;
        end
        default: begin
          code = second ? eblas_pkg::LANES_ALL
                        : eblas_pkg::L16_HALF1;
        end
      endcase
    end
    return code;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef enum logic [1:0] {
    EBLAS_IDLE,
    EBLAS_FIRST,
    EBLAS_WAIT,
    EBLAS_GRANT
  } eblas_state_t;

  eblas_state_t            state;
  eblas_state_t            next_state;
  eblas_pkg::eblas_req_t   cur;
  logic                    second;
  logic                    two_access;
  logic [3:0]              wait_cnt;
  logic                    foreign_busy;
  logic                    int_ready;
  logic                    ext_ready;
  logic                    access_end;
  logic                    last_access;
  logic                    req_take;
  logic                    foreign_strobe;

  assign ext_ready  = ~i_ready_n;
  assign int_ready  = (state == EBLAS_WAIT && cur.use_int_wait
                       && wait_cnt == 4'h0)
                   || (state == EBLAS_GRANT && foreign_busy
                       && wait_cnt == 4'h0);
  assign access_end = (state == EBLAS_WAIT)
                   && (ext_ready || int_ready);
  assign two_access = cur.bus16 && (!cur.write
                   || cur.size == eblas_pkg::EBLAS_WORD);
  assign last_access = !two_access || second;
  assign o_req_ready = (state == EBLAS_IDLE) && i_bus_request_n;
  assign req_take    = o_req_ready && i_req_valid;
  // strobe input is honoured only when the select pin allows it
  assign foreign_strobe = (state == EBLAS_GRANT) && !foreign_busy
                       && !i_transfer_strobe_n
                       && i_space_pin_select;
  assign o_combined_ready_out_n = ~(int_ready
                       || (ext_ready && (state == EBLAS_WAIT
                           || (state == EBLAS_GRANT && foreign_busy))));

  always_comb begin
    next_state = state;
    unique case (state)
      EBLAS_IDLE: begin
        if (!i_bus_request_n) begin
          next_state = EBLAS_GRANT;
        end else if (req_take) begin
          next_state = EBLAS_FIRST;
        end
      end
      EBLAS_FIRST: begin
        next_state = EBLAS_WAIT;
      end
      EBLAS_WAIT: begin
        if (access_end) begin
          if (!last_access) begin
            next_state = EBLAS_FIRST;
          end else if (!i_bus_request_n) begin
            next_state = EBLAS_GRANT;
          end else begin
            next_state = EBLAS_IDLE;
          end
        end
      end
      EBLAS_GRANT: begin
        if (i_bus_request_n && !foreign_busy) begin
          next_state = EBLAS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= EBLAS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request capture and access order

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cur    <= '0;
      second <= 1'b0;
    end else if (req_take) begin
      cur    <= i_req;
      second <= 1'b0;
    end else if (access_end && !last_access) begin
      second <= 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_done <= 1'b0;
    end else begin
      o_done <= access_end && last_access;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wait-state counter, own and foreign transfers

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      wait_cnt     <= 4'h0;
      foreign_busy <= 1'b0;
    end else if (state == EBLAS_FIRST) begin
      wait_cnt <= cur.waits;
    end else if (foreign_strobe) begin
      wait_cnt     <= P_FOREIGN_WAITS;
      foreign_busy <= 1'b1;
    end else if (foreign_busy && (int_ready || ext_ready)) begin
      foreign_busy <= 1'b0;
    end else if (wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_foreign_start <= 1'b0;
      o_foreign_space <= '0;
    end else begin
      o_foreign_start <= foreign_strobe;
      if (foreign_strobe) begin
        o_foreign_space <= i_space_identifier;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin drivers

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_transfer_strobe_n  <= 1'b1;
      o_transfer_strobe_oe <= 1'b1;
    end else begin
      o_transfer_strobe_n  <= !(next_state == EBLAS_FIRST);
      o_transfer_strobe_oe <= (next_state != EBLAS_GRANT);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_lane_enable_n  <= eblas_pkg::LANES_IDLE;
      o_lane_enable_oe <= 1'b1;
    end else begin
      o_lane_enable_oe <= (next_state != EBLAS_GRANT);
      if (next_state == EBLAS_FIRST) begin
        if (req_take) begin
          o_lane_enable_n <= lane_code(i_req.bus16, i_req.write,
                                       i_req.size, i_req.addr[1:0],
                                       1'b0);
        end else begin
          o_lane_enable_n <= lane_code(cur.bus16, cur.write, cur.size,
                                       cur.addr[1:0], 1'b1);
        end
      end else if (next_state != EBLAS_WAIT) begin
        o_lane_enable_n <= eblas_pkg::LANES_IDLE;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_addr                <= '0;
      o_space_identifier    <= '0;
      o_space_identifier_oe <= 1'b1;
    end else begin
      o_space_identifier_oe <= (next_state != EBLAS_GRANT);
      if (req_take) begin
        o_addr <= i_req.addr[eblas_pkg::LOW_ADDR_W-1:0];
        if (i_space_pin_select) begin
          o_space_identifier <= i_req.space;
        end else begin
          o_space_identifier <=
            i_req.addr[eblas_pkg::ADDR_W-1:eblas_pkg::LOW_ADDR_W];
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_bus_grant_n <= 1'b1;
    end else begin
      o_bus_grant_n <= !(next_state == EBLAS_GRANT);
    end
  end

endmodule // eblas_top

// *** bench/eblas_props.sv ***
// checker: strobe, lane, ready and grant relations at the top ports
`timescale 1ns/1ps
module eblas_props (
  input wire logic                        i_clk_sys,
  input wire logic                        i_nrst,
  input wire logic                        i_req_valid,
  input wire eblas_pkg::eblas_req_t       i_req,
  input wire logic                        o_req_ready,
  input wire logic                        o_done,
  input wire logic                        i_space_pin_select,
  input wire logic                        i_transfer_strobe_n,
  input wire logic                        o_transfer_strobe_n,
  input wire logic                        o_transfer_strobe_oe,
  input wire logic [eblas_pkg::LANES-1:0] o_lane_enable_n,
  input wire logic                        o_lane_enable_oe,
  input wire logic [3:0]                  o_space_identifier,
  input wire logic                        o_space_identifier_oe,
  input wire logic                        o_combined_ready_out_n,
  input wire logic                        o_bus_grant_n,
  input wire logic                        o_foreign_start
);
  logic take;
  logic w32;
  assign take = i_req_valid && o_req_ready;
  assign w32 = take && i_req.write && !i_req.bus16;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  ////////////////////////////////////////
  AST_SPACE_PINS: assert property (take |=> o_space_identifier ==
    ($past(i_space_pin_select) ? $past(i_req.space) : $past(i_req.addr[31:28])))
    else $error("top pins do not follow select");
  AST_STROBE_ONE: assert property (!o_transfer_strobe_n |=> o_transfer_strobe_n)
    else $error("strobe held past first cycle");
  AST_STROBE_START: assert property (take |=> !o_transfer_strobe_n)
    else $error("no strobe after take");
  AST_DONE_READY: assert property (o_done |-> $past(!o_combined_ready_out_n))
    else $error("done without ready");
  AST_READ32: assert property (take && !i_req.write && !i_req.bus16 |=>
    o_lane_enable_n == 4'h0) else $error("read lanes wrong");
  AST_BYTE32: assert property (w32 && i_req.size == eblas_pkg::EBLAS_BYTE
    |=> $onehot(~o_lane_enable_n)) else $error("byte lanes not one");
  AST_HALF32: assert property (w32 && i_req.size == eblas_pkg::EBLAS_HALF
    |=> o_lane_enable_n == ($past(i_req.addr[1]) ? 4'h3 : 4'hC))
    else $error("half lanes wrong");
  AST_GRANT_RELEASE: assert property (!o_bus_grant_n |->
    !o_transfer_strobe_oe && !o_lane_enable_oe && !o_req_ready
    && !o_space_identifier_oe)
    else $error("bus driven while granted");
  AST_FOREIGN_WAIT: assert property (o_foreign_start |->
    ##[1:16] !o_combined_ready_out_n)
    else $error("foreign transfer got no ready");
  AST_FOREIGN: assert property (!o_bus_grant_n && !i_transfer_strobe_n &&
    i_space_pin_select |=> ##[0:1] o_foreign_start)
    else $error("foreign strobe not taken");
endmodule // eblas_props
bind eblas_top eblas_props u_props (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
  .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
  .o_done(o_done), .i_space_pin_select(i_space_pin_select),
  .i_transfer_strobe_n(i_transfer_strobe_n),
  .o_transfer_strobe_n(o_transfer_strobe_n),
  .o_transfer_strobe_oe(o_transfer_strobe_oe),
  .o_lane_enable_n(o_lane_enable_n), .o_lane_enable_oe(o_lane_enable_oe),
  .o_space_identifier(o_space_identifier),
  .o_space_identifier_oe(o_space_identifier_oe),
  .o_combined_ready_out_n(o_combined_ready_out_n),
  .o_bus_grant_n(o_bus_grant_n), .o_foreign_start(o_foreign_start));

// *** bench/eblas_far.sv ***
// far-side memory model: answers each own strobe with one ready while i_answer is high
`timescale 1ns/1ps
module eblas_far (
  input  wire logic i_clk_sys,
  input  wire logic i_strobe_n,
  input  wire logic i_strobe_oe,
  input  wire logic i_answer,
  output logic      o_ready_n
);
  int unsigned d;
  initial o_ready_n = 1'b1;
  // ready low for one cycle, 0..3 cycles late; pull-up level between
  always @(posedge i_clk_sys) begin
    if (i_strobe_oe && i_strobe_n === 1'b0 && i_answer) begin
      d = $urandom_range(3);
      repeat (d) @(posedge i_clk_sys);
      #1 o_ready_n = 1'b0;
      @(posedge i_clk_sys);
      #1 o_ready_n = 1'b1;
    end
  end
endmodule // eblas_far

// *** bench/testbench.sv ***
// self-checking bench for the lane and strobe block
`timescale 1ns/1ps
module testbench;
  localparam logic [3:0] B16 [4] = '{4'h1, 4'h2, 4'h5, 4'h6};
  logic                  clk = 1'b0;
  logic                  nrst, req_valid, sel, fstb_n, bus_request_n_n, far_on;
  eblas_pkg::eblas_req_t req;
  logic [3:0]            sid_in;
  wire                   req_ready, done, stb_n, stb_oe, lane_oe, sid_oe;
  wire                   ready_n, crdy_n, grant_n, fstart;
  wire [3:0]             lanes, sid, fspace;
  wire [27:0]            addr;
  logic [3:0]            expq[$];
  int                    mismatches = 0;
  int                    comparisons = 0;
  always #12.5 clk = ~clk;
  eblas_top dut_u (.i_clk_sys(clk), .i_nrst(nrst), .i_req_valid(req_valid),
    .i_req(req), .o_req_ready(req_ready), .o_done(done),
    .i_space_pin_select(sel), .i_transfer_strobe_n(fstb_n),
    .o_transfer_strobe_n(stb_n), .o_transfer_strobe_oe(stb_oe),
    .o_lane_enable_n(lanes), .o_lane_enable_oe(lane_oe), .o_addr(addr),
    .o_space_identifier(sid), .o_space_identifier_oe(sid_oe),
    .i_space_identifier(sid_in), .i_ready_n(ready_n),
    .o_combined_ready_out_n(crdy_n), .i_bus_request_n(bus_request_n_n),
    .o_bus_grant_n(grant_n), .o_foreign_start(fstart),
    .o_foreign_space(fspace));
  eblas_far far_u (.i_clk_sys(clk), .i_strobe_n(stb_n), .i_strobe_oe(stb_oe),
    .i_answer(far_on), .o_ready_n(ready_n));
  ////////////////////////////////////////
  task check(string what, logic [3:0] exp, logic [3:0] got);
    comparisons++;
    if (exp !== got) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task finish_test;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // each own strobe takes the oldest expected lane code
  always @(posedge clk) if (nrst && stb_oe && stb_n === 1'b0) begin
    if (expq.size() == 0) check("spare strobe", 4'hE, 4'hF);
    else check("lanes", expq.pop_front(), lanes);
    check("space", sel ? req.space : req.addr[31:28], sid);
    check("addr", req.addr[27:24], addr[27:24]);
  end
  task xfer(bit b16, bit wr, eblas_pkg::eblas_size_t sz, logic [1:0] lo);
    int n;
    req = '0;
    req.addr = $urandom;
    req.addr[1:0] = lo;
    req.space = 4'($urandom_range(15));
    req.write = wr;
    req.size = sz;
    req.bus16 = b16;
    req.use_int_wait = 1'($urandom_range(1));
    req.waits = 4'($urandom_range(3));
    far_on = !req.use_int_wait;
    if (!b16) expq.push_back(!wr ? 4'h0 : sz == eblas_pkg::EBLAS_BYTE ?
      ~(4'h1 << lo) : sz == eblas_pkg::EBLAS_HALF ? (lo[1] ? 4'h3 : 4'hC)
      : 4'h0);
    else if (!wr) begin
      expq.push_back(4'h0);
      expq.push_back(4'h4);
    end else if (sz == eblas_pkg::EBLAS_WORD) begin
      expq.push_back(4'h4);
      expq.push_back(4'h0);
    end
    else if (sz == eblas_pkg::EBLAS_HALF) expq.push_back(lo[1] ? 4'h4 : 4'h0);
    else expq.push_back(B16[lo]);
    req_valid = 1'b1;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1 n++;
    end
    @(posedge clk);
    #1 req_valid = 1'b0;
    while (done !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1 n++;
    end
    check("done", 4'h1, {3'h0, done});
    check("queue left", 4'h0, 4'(expq.size()));
  endtask
  initial begin
    void'($urandom(32'hC2B7509A));
    {nrst, req_valid, fstb_n, bus_request_n_n, far_on, sel} = 6'h0E;
    req = '0;
    sid_in = 4'h0;
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
    for (int i = 0; i < 48; i++) begin
      sel = 1'($urandom_range(1));
      xfer(i[5], i[4], eblas_pkg::eblas_size_t'(i[3:2] % 3), i[1:0]);
    end
    sel = 1'b1;
    // request raised mid-transfer: release only after both accesses
    fork
      xfer(1'b1, 1'b1, eblas_pkg::EBLAS_WORD, 2'h0);
      begin
        @(posedge clk);
        #1 bus_request_n_n = 1'b0;
      end
    join
    for (int n = 0; n < 20 && grant_n !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
    #1 check("grant", 4'h0, {3'h0, grant_n});
    sid_in = 4'($urandom_range(15));
    fstb_n = 1'b0;
    @(posedge clk);
    #1 fstb_n = 1'b1;
    repeat (6) @(posedge clk);
    #1 check("foreign space", sid_in, fspace);
    bus_request_n_n = 1'b1;
    for (int n = 0; n < 20 && grant_n !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    #1 check("release", 4'h1, {3'h0, grant_n});
    xfer(1'b1, 1'b0, eblas_pkg::EBLAS_WORD, 2'h0);
    finish_test;
  end
  initial begin
    #2000000;
    mismatches++;
    finish_test;
  end
endmodule // testbench
